// ### bench/bcs_exec_properties.sv
// Assertions on the ports of the execution block
`timescale 1ns/1ps
`include "bcs_cfg.svh"

module bcs_exec_properties
    import bcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Inputs
    input wire bcs_instr_s instr,
    input wire logic [7:0] working_register,
    input wire logic [7:0] mem_rdata,
    // Outputs
    input wire bcs_mem_wr_s mem_wr,
    input wire logic [7:0] first_port_out,
    input wire logic [7:0] flags,
    input wire logic skip_pending,
    input wire logic retire,
    input wire logic discard
);
    // ****
    // Operands
    // ****
    logic run;
    logic cmp;
    logic [7:0] cx;
    logic [7:0] cy;
    assign run = instr.valid && !skip_pending;
    assign cmp = instr.op inside {BCS_OP_CEQ_WI, BCS_OP_CEQ_WM, BCS_OP_CEQ_MW, BCS_OP_CNE_WM};
    assign cx = (instr.op == BCS_OP_CEQ_MW) ? mem_rdata : working_register;
    assign cy = (instr.op == BCS_OP_CEQ_WI) ? instr.imm :
        ((instr.op == BCS_OP_CEQ_MW) ? working_register : mem_rdata);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_retire_each_instr: assert property (instr.valid |=> retire)
        else $error("retire missing");
    a_idle_no_effect: assert property (!instr.valid |=> !retire && !discard && !mem_wr.we)
        else $error("pulse without instruction");
    a_skip_discards: assert property (instr.valid && skip_pending |=>
        discard && !skip_pending && !mem_wr.we && $stable(flags)) else $error("skip had effect");
    a_bitop_keeps_flags: assert property (run && instr.io_addr != `BCS_IO_FLAG &&
        instr.op inside {[BCS_OP_CLEAR_IO:BCS_OP_RAISE_MEM]} |=> $stable(flags))
        else $error("bit op moved flags");
    a_raise_mem_byte: assert property (run && instr.op == BCS_OP_RAISE_MEM |=> mem_wr.we &&
        mem_wr.wdata == ($past(mem_rdata) | (8'h01 << $past(instr.bit_n))))
        else $error("memory raise wrong");
    a_clear_mem_byte: assert property (run && instr.op == BCS_OP_CLEAR_MEM |=> mem_wr.we &&
        mem_wr.wdata == ($past(mem_rdata) & ~(8'h01 << $past(instr.bit_n))))
        else $error("memory clear wrong");
    a_compare_flags: assert property (run && cmp |=> !mem_wr.we &&
        flags[1:0] == {$past(cx) < $past(cy), $past(cx) == $past(cy)}) else $error("compare flags");
    a_compare_skip: assert property (run && cmp |=> skip_pending ==
        (($past(cx) == $past(cy)) != $past(instr.op == BCS_OP_CNE_WM))) else $error("skip decision");
    a_swap_drives_carry: assert property (run && instr.op == BCS_OP_SWAP_IO &&
        instr.io_addr == `BCS_IO_P1_DATA |=> first_port_out[$past(instr.bit_n)] == $past(flags[1]))
        else $error("swap output wrong");
    c_skip_taken: cover property (run && cmp ##1 instr.valid && skip_pending);
    c_swap_port: cover property (run && instr.op == BCS_OP_SWAP_IO);
    c_raise_mem: cover property (run && instr.op == BCS_OP_RAISE_MEM);
endmodule : bcs_exec_properties

bind bcs_exec bcs_exec_properties i_bcs_exec_properties (.core_clk, .resetn, .instr,
    .working_register, .mem_rdata, .mem_wr, .first_port_out, .flags, .skip_pending, .retire,
    .discard);

// ### bench/bcs_exec_test.sv
// Self-checking bench of the execution block
`timescale 1ns/1ps
`include "bcs_cfg.svh"
`define CHK(nm, ex, got) \
    total_checks++; \
    if ((got) !== (ex)) begin \
        mismatches++; \
        $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end

module bcs_exec_test;
    import bcs_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    bcs_instr_s instr = '0;
    logic [7:0] working_register = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] p1_pins = 8'h00;
    logic [7:0] p2_pins = 8'h00;
    bcs_mem_wr_s mem_wr;
    logic [7:0] p1_out, p1_oe, p2_out, p2_oe, flags;
    logic skip_pending, retire, discard;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h1EE0AF89;
    // Expected state, zero out of reset except e_wd and e_wa, which start unset
    logic [7:0] e_fl = 8'h00, e_p1 = 8'h00, e_d1 = 8'h00, e_p2 = 8'h00, e_d2 = 8'h00, e_wd, e_wa;
    logic e_sk = 1'b0, e_ret = 1'b0, e_dis = 1'b0, e_we = 1'b0;
    logic [7:0] em [256] = '{default: 8'h00};
    bcs_op_e ops [12] = '{BCS_OP_NONE, BCS_OP_CLEAR_IO, BCS_OP_RAISE_IO, BCS_OP_TOGGLE_IO,
        BCS_OP_CLEAR_MEM, BCS_OP_RAISE_MEM, BCS_OP_SWAP_IO, BCS_OP_CEQ_WI, BCS_OP_CEQ_WM,
        BCS_OP_CEQ_MW, BCS_OP_CNE_WM, BCS_OP_OTHER};
    logic [5:0] ioa [6] = '{6'h00, 6'h10, 6'h11, 6'h14, 6'h15, 6'h3F};

    bcs_exec i_bcs_exec (.core_clk(core_clk), .resetn(resetn), .instr(instr),
        .working_register(working_register), .mem_rdata(mem_rdata), .first_port_pins(p1_pins),
        .second_port_pins(p2_pins), .mem_wr(mem_wr), .first_port_out(p1_out),
        .first_port_oe(p1_oe), .second_port_out(p2_out), .second_port_oe(p2_oe),
        .flags(flags), .skip_pending(skip_pending), .retire(retire), .discard(discard));

    always #2 core_clk = ~core_clk;

    // ****
    // Reference model
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] rd(input logic [5:0] a);
        return (a == 6'h00) ? e_fl : (a == 6'h10) ? e_p1 : (a == 6'h11) ? e_d1 :
            (a == 6'h14) ? e_p2 : (a == 6'h15) ? e_d2 : 8'h00;
    endfunction : rd

    // Unmapped addresses swallow writes
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        case (a)
            6'h00: e_fl = v & `BCS_FLAG_MASK;
            6'h10: e_p1 = v;
            6'h11: e_d1 = v;
            6'h14: e_p2 = v;
            6'h15: e_d2 = v;
            default: ;
        endcase
    endtask : wr

    task automatic predict();
        logic [7:0] v, m, x, y, d;
        logic b;
        e_ret = instr.valid;
        e_dis = instr.valid && e_sk;
        e_we = 1'b0;
        if (!instr.valid || e_sk) begin
            e_sk = e_sk && !instr.valid;
            return;
        end
        v = rd(instr.io_addr);
        m = 8'h01 << instr.bit_n;
        x = (instr.op == BCS_OP_CEQ_MW) ? mem_rdata : working_register;
        y = (instr.op == BCS_OP_CEQ_WI) ? instr.imm :
            ((instr.op == BCS_OP_CEQ_MW) ? working_register : mem_rdata);
        d = x - y;
        b = v[instr.bit_n];
        case (instr.op)
            BCS_OP_CLEAR_IO: wr(instr.io_addr, v & ~m);
            BCS_OP_RAISE_IO: wr(instr.io_addr, v | m);
            BCS_OP_TOGGLE_IO: wr(instr.io_addr, v ^ m);
            BCS_OP_CLEAR_MEM: e_wd = mem_rdata & ~m;
            BCS_OP_RAISE_MEM: e_wd = mem_rdata | m;
            BCS_OP_SWAP_IO: begin
                // Input pins hand their sampled level to carry
                if (instr.io_addr == 6'h10 && !e_d1[instr.bit_n]) b = p1_pins[instr.bit_n];
                if (instr.io_addr == 6'h14 && !e_d2[instr.bit_n]) b = p2_pins[instr.bit_n];
                wr(instr.io_addr, e_fl[1] ? (v | m) : (v & ~m));
                e_fl[1] = b;
            end
            BCS_OP_CEQ_WI, BCS_OP_CEQ_WM, BCS_OP_CEQ_MW, BCS_OP_CNE_WM: begin
                e_fl = {4'h0, x[7] != y[7] && d[7] != x[7], x[3:0] < y[3:0], x < y, d == 8'h00};
                e_sk = (x == y) != (instr.op == BCS_OP_CNE_WM);
            end
            default: ;
        endcase
        e_we = instr.op inside {BCS_OP_CLEAR_MEM, BCS_OP_RAISE_MEM};
        e_wa = instr.mem_addr;
        if (e_we) em[instr.mem_addr] = e_wd;
    endtask : predict

    // ****
    // Driving and checking
    // ****
    task automatic step(input bcs_op_e op, input logic [2:0] n, input logic [5:0] a,
        input logic [7:0] ma, input logic [7:0] im, input logic [7:0] w, input logic v);
        @(negedge core_clk);
        `CHK("retire", e_ret, retire)
        `CHK("discard", e_dis, discard)
        `CHK("skip", e_sk, skip_pending)
        `CHK("flags", e_fl, flags)
        `CHK("p1_out", e_p1, p1_out)
        `CHK("p1_oe", e_d1, p1_oe)
        `CHK("p2_out", e_p2, p2_out)
        `CHK("p2_oe", e_d2, p2_oe)
        `CHK("mem_we", e_we, mem_wr.we)
        if (e_we) begin
            `CHK("mem_data", e_wd, mem_wr.wdata)
            `CHK("mem_addr", e_wa, mem_wr.addr)
        end
        instr = '{v, op, n, a, ma, im};
        working_register = w;
        mem_rdata = em[ma];
        p1_pins = 8'(rnd());
        p2_pins = 8'(rnd());
        predict();
    endtask : step

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        logic [31:0] r;
        logic [7:0] ma, w;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        step(BCS_OP_NONE, 3'd0, 6'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        // Serial output through carry, then a hit whose follower is dropped
        step(BCS_OP_RAISE_IO, 3'd0, 6'h11, 8'h00, 8'h00, 8'h00, 1'b1);
        step(BCS_OP_CLEAR_IO, 3'd1, 6'h00, 8'h00, 8'h00, 8'h00, 1'b1);
        step(BCS_OP_SWAP_IO, 3'd0, 6'h10, 8'h00, 8'h00, 8'h00, 1'b1);
        step(BCS_OP_RAISE_IO, 3'd1, 6'h00, 8'h00, 8'h00, 8'h00, 1'b1);
        step(BCS_OP_SWAP_IO, 3'd0, 6'h10, 8'h00, 8'h00, 8'h00, 1'b1);
        step(BCS_OP_CEQ_WI, 3'd0, 6'h00, 8'h00, 8'h5A, 8'h5A, 1'b1);
        step(BCS_OP_RAISE_MEM, 3'd7, 6'h00, 8'h03, 8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 1500; i++) begin
            r = rnd();
            ma = {4'h0, r[15:12]};
            w = r[19] ? em[ma] : r[31:24];
            step(ops[r[3:0] % 12], r[6:4], ioa[r[10:8] % 6], ma, r[18] ? w : r[27:20], w,
                r[7] | r[17]);
        end
        step(BCS_OP_NONE, 3'd0, 6'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        test_done();
    end

    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule : bcs_exec_test

// ### inc/bcs_cfg.svh
// Constants of the bit-operation and compare-and-skip execution block
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH

// ****************************************
// IO addresses of the registers held here
// ****************************************
`define BCS_IO_FLAG 6'h00
`define BCS_IO_P1_DATA 6'h10
`define BCS_IO_P1_DIR 6'h11
`define BCS_IO_P2_DATA 6'h14
`define BCS_IO_P2_DIR 6'h15

// ****************************************
// Flag register bit positions
// ****************************************
`define BCS_FLAG_Z 0
`define BCS_FLAG_C 1
`define BCS_FLAG_HC 2
`define BCS_FLAG_SO 3
`define BCS_FLAG_MASK 8'h0F

// ****************************************
// Reset values and widths
// ****************************************
`define BCS_RST_BYTE 8'h00
`define BCS_MEM_AW 8
`define BCS_IO_AW 6
`define BCS_MSB 7
`define BCS_NIB_MSB 3

`endif

// ### inc/bcs_pkg.sv
// Types shared by the bit-operation and compare-and-skip execution block
`include "bcs_cfg.svh"

package bcs_pkg;

    // ****************************************
    // Operations
    // ****************************************
    typedef enum logic [3:0] {
        BCS_OP_NONE = 4'h0,
        BCS_OP_CLEAR_IO = 4'h1,
        BCS_OP_RAISE_IO = 4'h2,
        BCS_OP_TOGGLE_IO = 4'h3,
        BCS_OP_CLEAR_MEM = 4'h4,
        BCS_OP_RAISE_MEM = 4'h5,
        BCS_OP_SWAP_IO = 4'h6,
        BCS_OP_CEQ_WI = 4'h7,
        BCS_OP_CEQ_WM = 4'h8,
        BCS_OP_CEQ_MW = 4'h9,
        BCS_OP_CNE_WM = 4'hA,
        BCS_OP_OTHER = 4'hF
    } bcs_op_e;

    typedef enum logic [0:0] {
        BCS_RUN = 1'b0,
        BCS_SKIP = 1'b1
    } bcs_mode_e;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        bcs_op_e op;
        logic [2:0] bit_n;
        logic [`BCS_IO_AW-1:0] io_addr;
        logic [`BCS_MEM_AW-1:0] mem_addr;
        logic [7:0] imm;
    } bcs_instr_s;

    typedef struct packed {
        logic we;
        logic [`BCS_MEM_AW-1:0] addr;
        logic [7:0] wdata;
    } bcs_mem_wr_s;

    typedef struct packed {
        bcs_mode_e mode;
        logic [7:0] flags;
        logic [7:0] first_port_data;
        logic [7:0] first_port_dir;
        logic [7:0] second_port_data;
        logic [7:0] second_port_dir;
        bcs_mem_wr_s mem_wr;
        logic retire;
        logic discard;
    } bcs_state_s;

endpackage : bcs_pkg

// ### rtl/bcs_exec.sv
// Execution of single-bit operations and compare-and-skip instructions
// Behaviour
// - Clear-bit on IO register forces bit n low, flags untouched unless it targets the flag register.
// - Set-bit on IO register forces bit n high, flags untouched unless it targets the flag register.
// - Toggle inverts bit n of the IO register, flags untouched unless it targets the flag register.
// - Clear-bit on memory byte writes 0 to bit n, others kept.
// - Set-bit on memory byte writes 1 to bit n, others kept.
// - Carry-swap exchanges IO bit n with carry; only bit n and carry change.
// - Output-configured swapped bit drives the previous carry onto the pin.
// - Input-configured swapped bit loads the sampled pin level into carry.
// - Carry is bit 1 of the flag register, writable by bit ops.
// - Direction bit 1 makes the pin an output.
// - Equal-skip immediate compares working register, skips on match.
// - Equal-skip with memory, either order, skips on match.
// - Not-equal-skip with memory skips only when operands differ.
// - Compares set flags as subtraction, store no difference.
`timescale 1ns/1ps

module bcs_exec
    import bcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Instruction and operands
    input wire bcs_instr_s instr,
    input wire logic [7:0] working_register,
    input wire logic [7:0] mem_rdata,
    // Pin levels
    input wire logic [7:0] first_port_pins,
    input wire logic [7:0] second_port_pins,
    // Data memory write
    output bcs_mem_wr_s mem_wr,
    // Port drivers
    output logic [7:0] first_port_out,
    output logic [7:0] first_port_oe,
    output logic [7:0] second_port_out,
    output logic [7:0] second_port_oe,
    // Status
    output logic [7:0] flags,
    output logic skip_pending,
    output logic retire,
    output logic discard
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] put_bit(
        input logic [7:0] v,
        input logic [2:0] n,
        input logic b
    );
        logic [7:0] r;
        r = v;
        r[n] = b;
        return r;
    endfunction : put_bit

    function automatic logic [7:0] io_read(
        input bcs_state_s s,
        input logic [`BCS_IO_AW-1:0] a
    );
        logic [7:0] r;
        r = `BCS_RST_BYTE;
        case (a)
            `BCS_IO_FLAG: r = s.flags;
            `BCS_IO_P1_DATA: r = s.first_port_data;
            `BCS_IO_P1_DIR: r = s.first_port_dir;
            `BCS_IO_P2_DATA: r = s.second_port_data;
            `BCS_IO_P2_DIR: r = s.second_port_dir;
            default: r = `BCS_RST_BYTE;
        endcase
        return r;
    endfunction : io_read

    // Non-port registers behave as outputs, so a swap is a plain exchange
    function automatic logic [7:0] io_dir(
        input bcs_state_s s,
        input logic [`BCS_IO_AW-1:0] a
    );
        logic [7:0] r;
        r = ~`BCS_RST_BYTE;
        case (a)
            `BCS_IO_P1_DATA: r = s.first_port_dir;
            `BCS_IO_P2_DATA: r = s.second_port_dir;
            default: r = ~`BCS_RST_BYTE;
        endcase
        return r;
    endfunction : io_dir

    function automatic logic [7:0] io_pins(
        input logic [`BCS_IO_AW-1:0] a,
        input logic [7:0] p1,
        input logic [7:0] p2,
        input logic [7:0] latch
    );
        logic [7:0] r;
        r = latch;
        case (a)
            `BCS_IO_P1_DATA: r = p1;
            `BCS_IO_P2_DATA: r = p2;
            default: r = latch;
        endcase
        return r;
    endfunction : io_pins

    // Write-back of an IO register; unmapped addresses swallow the write
    function automatic bcs_state_s io_write(
        input bcs_state_s s,
        input logic [`BCS_IO_AW-1:0] a,
        input logic [7:0] v
    );
        bcs_state_s r;
        r = s;
        case (a)
            `BCS_IO_FLAG: r.flags = v & `BCS_FLAG_MASK;
            `BCS_IO_P1_DATA: r.first_port_data = v;
            `BCS_IO_P1_DIR: r.first_port_dir = v;
            `BCS_IO_P2_DATA: r.second_port_data = v;
            `BCS_IO_P2_DIR: r.second_port_dir = v;
            default: r = s;
        endcase
        return r;
    endfunction : io_write

    // Flags of x - y; the difference itself is dropped
    function automatic logic [7:0] sub_flags(
        input logic [7:0] x,
        input logic [7:0] y
    );
        logic [8:0] diff;
        logic [7:0] f;
        diff = {1'b0, x} - {1'b0, y};
        f = `BCS_RST_BYTE;
        f[`BCS_FLAG_Z] = (diff[7:0] == `BCS_RST_BYTE);
        f[`BCS_FLAG_C] = diff[8];
        f[`BCS_FLAG_HC] = (x[`BCS_NIB_MSB:0] < y[`BCS_NIB_MSB:0]);
        f[`BCS_FLAG_SO] = (x[`BCS_MSB] != y[`BCS_MSB]) && (diff[`BCS_MSB] != x[`BCS_MSB]);
        return f;
    endfunction : sub_flags

    // ****************************************
    // Compare helpers
    // ****************************************
    // The memory-first form subtracts the working register from the byte
    function automatic logic [7:0] cmp_lhs(
        input bcs_op_e op,
        input logic [7:0] w,
        input logic [7:0] m
    );
        return (op == BCS_OP_CEQ_MW) ? m : w;
    endfunction : cmp_lhs

    function automatic logic [7:0] cmp_rhs(
        input bcs_op_e op,
        input logic [7:0] w,
        input logic [7:0] m,
        input logic [7:0] imm
    );
        logic [7:0] r;
        r = m;
        case (op)
            BCS_OP_CEQ_WI: r = imm;
            BCS_OP_CEQ_MW: r = w;
            default: r = m;
        endcase
        return r;
    endfunction : cmp_rhs

    // Skip on equality, or on inequality for the not-equal form
    function automatic logic cmp_skip(
        input bcs_op_e op,
        input logic [7:0] x,
        input logic [7:0] y
    );
        return (op == BCS_OP_CNE_WM) ? (x != y) : (x == y);
    endfunction : cmp_skip

    // ****************************************
    // State
    // ****************************************
    bcs_state_s q;
    bcs_state_s d;
    logic [7:0] io_old;
    logic [7:0] io_new;
    logic io_we;
    logic carry_we;
    logic carry_new;
    logic [7:0] pin_lvl;
    logic [7:0] dir_lvl;
    logic [7:0] cmp_flags;
    logic [7:0] cmp_x;
    logic [7:0] cmp_y;
    logic cmp_hit;

    always_comb begin
        d = q;
        d.mem_wr.we = 1'b0;
        d.retire = 1'b0;
        d.discard = 1'b0;
        io_old = io_read(q, instr.io_addr);
        dir_lvl = io_dir(q, instr.io_addr);
        pin_lvl = io_pins(instr.io_addr, first_port_pins, second_port_pins, io_old);
        io_new = io_old;
        io_we = 1'b0;
        carry_we = 1'b0;
        carry_new = q.flags[`BCS_FLAG_C];
        cmp_flags = `BCS_RST_BYTE;
        cmp_hit = 1'b0;
        cmp_x = cmp_lhs(instr.op, working_register, mem_rdata);
        cmp_y = cmp_rhs(instr.op, working_register, mem_rdata, instr.imm);
        if (instr.valid) begin
            d.retire = 1'b1;
            if (q.mode == BCS_SKIP) begin
                // Fetched but dropped: no register, memory or flag changes
                d.discard = 1'b1;
                d.mode = BCS_RUN;
            end else begin
                case (instr.op)
                    BCS_OP_CLEAR_IO: begin
                        io_new = put_bit(io_old, instr.bit_n, 1'b0);
                        io_we = 1'b1;
                    end
                    BCS_OP_RAISE_IO: begin
                        io_new = put_bit(io_old, instr.bit_n, 1'b1);
                        io_we = 1'b1;
                    end
                    BCS_OP_TOGGLE_IO: begin
                        io_new = put_bit(io_old, instr.bit_n, ~io_old[instr.bit_n]);
                        io_we = 1'b1;
                    end
                    BCS_OP_CLEAR_MEM: begin
                        d.mem_wr.we = 1'b1;
                        d.mem_wr.addr = instr.mem_addr;
                        d.mem_wr.wdata = put_bit(mem_rdata, instr.bit_n, 1'b0);
                    end
                    BCS_OP_RAISE_MEM: begin
                        d.mem_wr.we = 1'b1;
                        d.mem_wr.addr = instr.mem_addr;
                        d.mem_wr.wdata = put_bit(mem_rdata, instr.bit_n, 1'b1);
                    end
                    BCS_OP_SWAP_IO: begin
                        // Latch takes old carry; an output pin then shows it
                        io_new = put_bit(io_old, instr.bit_n, q.flags[`BCS_FLAG_C]);
                        io_we = 1'b1;
                        carry_we = 1'b1;
                        if (dir_lvl[instr.bit_n]) begin
                            carry_new = io_old[instr.bit_n];
                        end else begin
                            carry_new = pin_lvl[instr.bit_n];
                        end
                    end
                    BCS_OP_CEQ_WI, BCS_OP_CEQ_WM, BCS_OP_CEQ_MW, BCS_OP_CNE_WM: begin
                        cmp_flags = sub_flags(cmp_x, cmp_y);
                        cmp_hit = cmp_skip(instr.op, cmp_x, cmp_y);
                        d.flags = cmp_flags;
                    end
                    default: begin
                        io_we = 1'b0;
                    end
                endcase
                if (cmp_hit) begin
                    d.mode = BCS_SKIP;
                end
            end
        end
        if (io_we) begin
            d = io_write(d, instr.io_addr, io_new);
        end
        // Carry update last so a swap on the flag register still exchanges
        if (carry_we) begin
            d.flags[`BCS_FLAG_C] = carry_new;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            q.mode <= BCS_RUN;
            q.flags <= `BCS_RST_BYTE;
            q.first_port_data <= `BCS_RST_BYTE;
            q.first_port_dir <= `BCS_RST_BYTE;
            q.second_port_data <= `BCS_RST_BYTE;
            q.second_port_dir <= `BCS_RST_BYTE;
            q.mem_wr.we <= 1'b0;
            q.mem_wr.addr <= {`BCS_MEM_AW{1'b0}};
            q.mem_wr.wdata <= `BCS_RST_BYTE;
            q.retire <= 1'b0;
            q.discard <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign mem_wr = q.mem_wr;
    assign first_port_out = q.first_port_data;
    assign first_port_oe = q.first_port_dir;
    assign second_port_out = q.second_port_data;
    assign second_port_oe = q.second_port_dir;
    assign flags = q.flags;
    assign skip_pending = (q.mode == BCS_SKIP);
    assign retire = q.retire;
    assign discard = q.discard;

endmodule : bcs_exec
